// [flash_timing_pkg.sv]
// Package: constants and carrier types for the flash operation timing sequencer
package flash_timing_pkg;
  // Widths
  localparam int DIV_W = 8;
  localparam int CNT_W = 17;
  localparam int ADDR_W = 16;
  // Single word program: op-clock periods and bus periods
  localparam logic [CNT_W-1:0] SWPGM_OP_CYC = 17'h00009;
  localparam logic [CNT_W-1:0] SWPGM_BUS_CYC = 17'h00019;
  // Burst consecutive word: op-clock periods and bus periods
  localparam logic [CNT_W-1:0] BWPGM_OP_CYC = 17'h00004;
  localparam logic [CNT_W-1:0] BWPGM_BUS_CYC = 17'h00009;
  // Words per burst row
  localparam logic [6:0] ROW_WORDS = 7'h40;
  // Sector erase: pulses and op-clock periods in total
  localparam logic [4:0] ERA_PULSES = 5'h10;
  localparam logic [CNT_W-1:0] ERA_OP_CYC = 17'h00FA0;
  localparam logic [CNT_W-1:0] ERA_PULSE_OP_CYC = 17'h000FA;
  // Mass erase op-clock periods
  localparam logic [CNT_W-1:0] MASS_OP_CYC = 17'h04E20;
  // Blank check setup bus cycles: 11 minimum less one word
  localparam logic [CNT_W-1:0] BLANK_SETUP_CYC = 17'h0000A;
  // Blank check words in a block: 65546 maximum less setup
  localparam logic [CNT_W-1:0] BLANK_WORDS = 17'h10000;

  typedef enum logic [2:0] {
    CMD_PROGRAM,
    CMD_SECTOR_ERASE,
    CMD_MASS_ERASE,
    CMD_BLANK_CHECK
  } cmd_e;

  typedef struct packed {
    cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
  } cmd_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic blank_fail;
    logic [ADDR_W-1:0] fail_addr;
  } stat_s;
endpackage

// [flash_program_erase_timing.sv]
// Flash program, erase and blank check timing sequencer
`timescale 1ns/1ns
module flash_program_erase_timing #(
  parameter int DIV_W = flash_timing_pkg::DIV_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [DIV_W-1:0] flash_clock_divider_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire flash_timing_pkg::cmd_s cmd_i,
  input wire logic word_blank_i,
  output logic [flash_timing_pkg::ADDR_W-1:0] array_addr_o,
  output logic prog_strobe_o,
  output logic erase_pulse_o,
  output logic flash_operation_clock_o,
  output flash_timing_pkg::stat_s stat_o
);
  typedef enum logic [2:0] {S_IDLE, S_OP, S_BUS, S_BLANK_SETUP, S_BLANK_SCAN} state_e;

  localparam int CW = flash_timing_pkg::CNT_W;
  localparam int AW = flash_timing_pkg::ADDR_W;

  state_e state_q;
  flash_timing_pkg::cmd_e cmd_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic op_tick;
  logic op_clk_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] bus_len_q;
  logic [6:0] words_q;
  logic [4:0] pulses_q;
  logic [AW-1:0] addr_q;
  logic busy_q;
  logic done_q;
  logic fail_q;
  logic [AW-1:0] fail_addr_q;
  logic accept;
  logic burst_next;

  ////////////////////////////////////////////////////////////////////////////
  // Operation clock divider
  // Divider is not checked against any limit; a bad setting only stretches or compresses time
  // no frequency check
  assign op_tick = (div_cnt_q == flash_clock_divider_i);

  // Divider counter, one tick per op-clock period (divider plus one bus cycles)
  // Restarts outside the op phase so a burst word never starts on a partial period
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_q <= '0;
    end else if (op_tick || state_q != S_OP) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // Visible op clock toggles on each tick while busy
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_clk_q <= 1'b0;
    end else if (op_tick && busy_q) begin
      op_clk_q <= ~op_clk_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command handshake
  // commands blocked while busy
  assign cmd_ready_o = !busy_q;
  assign accept = cmd_valid_i && cmd_ready_o;
  // A program command already queued at the end of a word continues the burst, up to 64 words per row
  // burst while queued
  assign burst_next = cmd_valid_i && (cmd_i.cmd == flash_timing_pkg::CMD_PROGRAM)
    && (cmd_q == flash_timing_pkg::CMD_PROGRAM) && (words_q < flash_timing_pkg::ROW_WORDS);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= S_IDLE;
      cmd_q <= flash_timing_pkg::CMD_PROGRAM;
      cnt_q <= '0;
      bus_len_q <= '0;
      words_q <= '0;
      pulses_q <= '0;
      addr_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (accept) begin
            cmd_q <= cmd_i.cmd;
            addr_q <= cmd_i.addr;
            cnt_q <= '0;
            pulses_q <= '0;
            case (cmd_i.cmd)
              flash_timing_pkg::CMD_PROGRAM: begin
                words_q <= 7'h01;
                bus_len_q <= flash_timing_pkg::SWPGM_BUS_CYC;
                state_q <= S_OP;
              end
              flash_timing_pkg::CMD_BLANK_CHECK: begin
                addr_q <= '0;
                state_q <= S_BLANK_SETUP;
              end
              default: begin
                state_q <= S_OP;
              end
            endcase
          end
        end
        S_OP: begin
          if (op_tick) begin
            cnt_q <= cnt_q + 1'b1;
            case (cmd_q)
              flash_timing_pkg::CMD_PROGRAM: begin
                if ((words_q == 7'h01 && cnt_q == flash_timing_pkg::SWPGM_OP_CYC - 1'b1) ||
                    (words_q != 7'h01 && cnt_q == flash_timing_pkg::BWPGM_OP_CYC - 1'b1)) begin
                  cnt_q <= '0;
                  state_q <= S_BUS;
                end
              end
              flash_timing_pkg::CMD_SECTOR_ERASE: begin
                if (cnt_q == flash_timing_pkg::ERA_PULSE_OP_CYC - 1'b1) begin
                  cnt_q <= '0;
                  pulses_q <= pulses_q + 1'b1;
                  if (pulses_q == flash_timing_pkg::ERA_PULSES - 1'b1) begin
                    state_q <= S_IDLE;
                  end
                end
              end
              default: begin
                if (cnt_q == flash_timing_pkg::MASS_OP_CYC - 1'b1) begin
                  state_q <= S_IDLE;
                end
              end
            endcase
          end
        end
        S_BUS: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == bus_len_q - 1'b1) begin
            cnt_q <= '0;
            // row is single then burst words
            if (burst_next) begin
              words_q <= words_q + 1'b1;
              addr_q <= cmd_i.addr;
              bus_len_q <= flash_timing_pkg::BWPGM_BUS_CYC;
              state_q <= S_OP;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_BLANK_SETUP: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == flash_timing_pkg::BLANK_SETUP_CYC - 1'b1) begin
            cnt_q <= '0;
            state_q <= S_BLANK_SCAN;
          end
        end
        S_BLANK_SCAN: begin
          cnt_q <= cnt_q + 1'b1;
          addr_q <= addr_q + 1'b1;
          if (!word_blank_i || cnt_q == flash_timing_pkg::BLANK_WORDS - 1'b1) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status: busy, done pulse and blank-check result
  // busy until count elapsed
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && (state_q == S_IDLE);
      if (accept) begin
        busy_q <= 1'b1;
      end else if (state_q == S_IDLE) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Result of the last blank check; fail address is the first non-blank word
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fail_q <= 1'b0;
      fail_addr_q <= '0;
    end else if (accept && cmd_i.cmd == flash_timing_pkg::CMD_BLANK_CHECK) begin
      fail_q <= 1'b0;
    end else if (state_q == S_BLANK_SCAN && !word_blank_i) begin
      fail_q <= 1'b1;
      fail_addr_q <= addr_q;
    end
  end

  // Strobes registered from the sequencer state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_strobe_o <= 1'b0;
      erase_pulse_o <= 1'b0;
    end else begin
      prog_strobe_o <= (state_q == S_OP) && (cmd_q == flash_timing_pkg::CMD_PROGRAM);
      // one idle cycle between sector pulses, so each pulse is seen on its own
      erase_pulse_o <= (state_q == S_OP) && (cmd_q != flash_timing_pkg::CMD_PROGRAM)
        && !(cmd_q == flash_timing_pkg::CMD_SECTOR_ERASE && op_tick
             && cnt_q == flash_timing_pkg::ERA_PULSE_OP_CYC - 1'b1);
    end
  end

  assign array_addr_o = addr_q;
  assign flash_operation_clock_o = op_clk_q;
  assign stat_o = '{busy: busy_q, done: done_q, blank_fail: fail_q, fail_addr: fail_addr_q};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_busy_on_accept: assert property (@(posedge clock_i) disable iff (!nrst_i)
    accept |=> busy_q && !cmd_ready_o) else $error("busy not raised after launch");
  chk_bus_phase_len: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(state_q == S_BUS) && words_q == 7'h01 |-> (state_q == S_BUS) [*8] ##1 (state_q == S_BUS) [*8]
    ##1 (state_q == S_BUS) [*8] ##1 state_q == S_BUS ##1 state_q != S_BUS)
    else $error("single word bus phase not 25 cycles");
  chk_burst_bus_len: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(state_q == S_BUS) && words_q != 7'h01 |-> (state_q == S_BUS) [*8] ##1 state_q == S_BUS
    ##1 state_q != S_BUS)
    else $error("burst word bus phase not 9 cycles");
  chk_burst_limit: assert property (@(posedge clock_i) disable iff (!nrst_i)
    words_q <= flash_timing_pkg::ROW_WORDS) else $error("burst exceeds row");
  chk_pulse_count: assert property (@(posedge clock_i) disable iff (!nrst_i)
    pulses_q <= flash_timing_pkg::ERA_PULSES) else $error("too many erase pulses");
  chk_blank_setup: assert property (@(posedge clock_i) disable iff (!nrst_i)
    accept && cmd_i.cmd == flash_timing_pkg::CMD_BLANK_CHECK |=> (state_q == S_BLANK_SETUP) [*8])
    else $error("blank setup too short");
  chk_blank_stop: assert property (@(posedge clock_i) disable iff (!nrst_i)
    state_q == S_BLANK_SCAN && !word_blank_i |=> state_q == S_IDLE && fail_q)
    else $error("blank check did not stop");
  chk_done_after: assert property (@(posedge clock_i) disable iff (!nrst_i)
    busy_q && state_q == S_IDLE && !accept |=> done_q && !busy_q) else $error("no done pulse");
endmodule

// [flash_program_erase_timing_tb_top.sv]
// Self-checking testbench for the flash program, erase and blank check timing sequencer
`timescale 1ns/1ns
module flash_program_erase_timing_tb_top;
  logic clock_i;
  logic nrst_i;
  logic [7:0] flash_clock_divider;
  logic cmd_valid_i;
  logic cmd_ready;
  flash_timing_pkg::cmd_s cmd;
  logic word_blank_i;
  logic [15:0] array_addr;
  logic erase_pulse;
  logic prog_strobe;
  logic op_clock;
  int toggles;
  flash_timing_pkg::stat_s stat;
  logic [16:0] fail_at;
  int mismatches;
  int checks_done;
  int a;
  int b;
  int c;
  int p;

  ////////////////////////////////////////////////////////////////////////////////
  flash_program_erase_timing i_flash_program_erase_timing (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .flash_clock_divider_i(flash_clock_divider),
    .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready),
    .cmd_i(cmd),
    .word_blank_i(word_blank_i),
    .array_addr_o(array_addr),
    .prog_strobe_o(prog_strobe),
    .erase_pulse_o(erase_pulse),
    .flash_operation_clock_o(op_clock),
    .stat_o(stat)
  );

  // Array model: words below fail_at read as blank, the rest hold data
  assign word_blank_i = ({1'b0, array_addr} < fail_at);

  // bus clock 100 MHz, well above the program minimum
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Launch one command and count bus edges from acceptance to the done pulse;
  // hold keeps the request up so program words chain into a burst
  task automatic run_op(input flash_timing_pkg::cmd_e op, input logic [7:0] div, input logic hold,
                        output int cyc, output int pulses);
    int bad;
    logic prev;
    logic prev_clk;
    flash_clock_divider = div;
    cmd.cmd = op;
    cmd.addr = 16'h1234;
    cmd.data = 16'hA5C3;
    cmd_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
    if (!hold) begin
      cmd_valid_i = 1'b0;
    end
    cyc = 1;
    pulses = 0;
    toggles = 0;
    bad = 0;
    prev = erase_pulse | prog_strobe;
    prev_clk = op_clock;
    while (stat.done !== 1'b1) begin
      if (stat.busy !== 1'b1 || cmd_ready !== 1'b0) begin
        bad++;
      end
      @(posedge clock_i);
      #1;
      cyc++;
      // Pulses counts rises of either strobe; they never overlap
      if ((erase_pulse | prog_strobe) === 1'b1 && prev !== 1'b1) begin
        pulses++;
      end
      prev = erase_pulse | prog_strobe;
      if (op_clock !== prev_clk) begin
        toggles++;
      end
      prev_clk = op_clock;
      // Bounded wait: a hung sequence ends the run
      if (cyc > 70000) begin
        mismatches++;
        complete_run();
      end
    end
    cmd_valid_i = 1'b0;
    // Let one edge pass so the next request is not raised in the same step
    @(posedge clock_i);
    #1;
    check_val(32'(bad), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // not kept: dividers far below the software range compress run time
  // Each op period adds exactly one bus cycle per unit of divider
  task automatic sc_program;
    run_op(flash_timing_pkg::CMD_PROGRAM, 8'h00, 1'b0, a, p);
    check_val(32'(p), 32'h1);
    run_op(flash_timing_pkg::CMD_PROGRAM, 8'h01, 1'b0, b, p);
    check_val(32'(toggles), 32'h9);
    run_op(flash_timing_pkg::CMD_PROGRAM, 8'hFF, 1'b0, c, p);
    check_val(32'(b - a), 32'h9);
    check_val({31'h0, a >= 34 && a <= 38}, 32'h1);
    check_val(32'(c - a), 32'(9 * 255));
  endtask

  task automatic sc_burst;
    run_op(flash_timing_pkg::CMD_PROGRAM, 8'h00, 1'b1, a, p);
    check_val(32'(p), 32'h40);
    run_op(flash_timing_pkg::CMD_PROGRAM, 8'h01, 1'b1, b, p);
    check_val(32'(b - a), 32'(9 + 63 * 4));
    check_val({31'h0, a >= 34 + 63 * 13 && a <= 38 + 63 * 13}, 32'h1);
  endtask

  task automatic sc_erase;
    run_op(flash_timing_pkg::CMD_SECTOR_ERASE, 8'h00, 1'b0, a, p);
    check_val(32'(p), 32'h10);
    run_op(flash_timing_pkg::CMD_SECTOR_ERASE, 8'h01, 1'b0, b, p);
    check_val(32'(b - a), 32'hFA0);
    run_op(flash_timing_pkg::CMD_MASS_ERASE, 8'h00, 1'b0, c, p);
    check_val({31'h0, c >= 20000 && c <= 20004}, 32'h1);
  endtask

  // Scan starts at word zero whatever address the command carried
  task automatic sc_blank;
    fail_at = 17'h00000;
    run_op(flash_timing_pkg::CMD_BLANK_CHECK, 8'h00, 1'b0, a, p);
    check_val({31'h0, stat.blank_fail}, 32'h1);
    check_val({16'h0, stat.fail_addr}, 32'h0);
    check_val({31'h0, a >= 11 && a <= 14}, 32'h1);
    fail_at = 17'h0012C;
    run_op(flash_timing_pkg::CMD_BLANK_CHECK, 8'h00, 1'b0, b, p);
    check_val({16'h0, stat.fail_addr}, 32'h12C);
    check_val(32'(b - a), 32'h12C);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 12 cycles, then every scenario once
  initial begin
    mismatches = 0;
    checks_done = 0;
    nrst_i = 1'b0;
    flash_clock_divider = 8'h00;
    cmd_valid_i = 1'b0;
    cmd = '0;
    fail_at = 17'h1FFFF;
    repeat (12) @(posedge clock_i);
    #1;
    nrst_i = 1'b1;
    check_val({31'h0, cmd_ready}, 32'h1);
    sc_program();
    sc_burst();
    sc_erase();
    sc_blank();
    complete_run();
  end
endmodule
